// >>> tse_map.svh
/*
 * Constants for the trap syndrome encoder: exception class codes,
 * syndrome field positions, fixed field values and register offsets.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef TSE_MAP_SVH
`define TSE_MAP_SVH

// exception class codes
`define TSE_CLS_SINGLE_SYS   6'h03
`define TSE_CLS_SINGLE_DBG   6'h05
`define TSE_CLS_ID_GROUP     6'h08
`define TSE_CLS_DUAL_SYS     6'h04
`define TSE_CLS_DUAL_DBG     6'h0C
`define TSE_CLS_MEM_COPROC   6'h06
`define TSE_CLS_UNKNOWN      6'h00

// coprocessor numbers
`define TSE_CP_SYS           4'hF
`define TSE_CP_DBG           4'hE

// fixed field values
`define TSE_CC_ALWAYS        4'hE
`define TSE_SECOP_FLOAT      4'h0
`define TSE_MODE_LITERAL_BIT 2

// syndrome field positions (lsb)
`define TSE_POS_CC_VALID     24
`define TSE_POS_CC           20
`define TSE_POS_OPCODE_A     16
`define TSE_POS_IMMEDIATE    12
`define TSE_POS_XFER2        10
`define TSE_POS_XFER         5
`define TSE_POS_OFFSET_DIR   4
`define TSE_POS_SECOP        1
`define TSE_POS_ADDR_MODE    1
`define TSE_POS_DIR          0

// wishbone register offsets (byte addresses)
`define TSE_REG_CTRL         8'h00
`define TSE_REG_SYNDROME     8'h04
`define TSE_REG_CLASS        8'h08
`define TSE_REG_COUNT        8'h0C

// control register reset value
`define TSE_CTRL_RESET       2'h0

`endif

// >>> tse_pkg.sv
/*
 * Types for the trap syndrome encoder.
 * Assumes tse_map.svh supplies the numeric constants.
 */
package tse_pkg;

    // kind of trapped coprocessor access
    typedef enum logic [2:0]
    {
        TSE_SINGLE_WRITE,
        TSE_SINGLE_READ,
        TSE_FLOAT_READ,
        TSE_DUAL_WRITE,
        TSE_DUAL_READ,
        TSE_MEM_STORE,
        TSE_MEM_LOAD
    } tse_kind_t;

    // decoded fields of the trapped instruction
    typedef struct packed
    {
        tse_kind_t  kind;
        logic       compact_set;
        logic       conditional;
        logic [3:0] condition_code_field;
        logic [3:0] coproc;
        logic       id_group;
        logic [3:0] first_opcode_field;
        logic [3:0] transfer_register_index;
        logic [3:0] second_transfer_register_index;
        logic [3:0] base_register_index;
        logic [3:0] secondary_opcode_register_field;
        logic [7:0] eight_bit_immediate;
        logic [2:0] addressing_mode_field;
        logic       offset_add;
    } tse_trap_t;

    // captured syndrome
    typedef struct packed
    {
        logic [5:0]  exception_class;
        logic [24:0] instruction_specific_syndrome;
    } tse_syndrome_t;

endpackage

// >>> tse_trap_syndrome_encoder.sv
/*
 * Trap syndrome encoder: turns a decoded trapped coprocessor access into
 * an exception class and instruction specific syndrome, captures them,
 * and exposes them plus a control register over classic Wishbone.
 * Assumes trap_i is a one-cycle strobe from core logic on clk_i.
 */
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ns

`include "tse_map.svh"

// Summary of operation
// - single format: transfer register in bits 8:5
// - secondary opcode field bits 4:1, float read zero
// - single direction bit: write 0, read 1
// - single class codes 03, 05, 08
// - dual format for coproc 1111, 1110 reads
// - bit 24 valid flag, wide set always 1
// - compact set: valid flag per control choice
// - condition field or 1110 when unconditional
// - passing conditional may report 1110 instead
// - dual format first opcode in 19:16
// - dual format second register in 13:10
// - dual format first register in 8:5
// - dual direction bit: write 0, read 1
// - dual class codes 04, 0C
// - memory accesses use load/store format
// - eight-bit immediate into bits 19:12
// - base register only for immediate forms
// - bit 4 reflects add/subtract bit
// - bits 3:1 carry addressing mode
// - load/store direction: store 0, load 1
module tse_trap_syndrome_encoder
    import tse_pkg::*;
(
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // trap capture
    input  wire logic          trap_i,
    input  wire tse_trap_t     trap_info_i,
    output logic               captured_o,
    output tse_syndrome_t      syndrome_o,
    // wishbone slave
    input  wire logic          cyc_i,
    input  wire logic          stb_i,
    input  wire logic          we_i,
    input  wire logic [7:0]    adr_i,
    input  wire logic [3:0]    sel_i,
    input  wire logic [31:0]   dat_i,
    output logic [31:0]        dat_o,
    output logic               ack_o
);

    // control: bit0 compact set reports condition, bit1 passing condition_code_field shows 1110
    logic [1:0]     ctrl;
    logic [15:0]    trap_count;
    tse_syndrome_t  next_syndrome;
    logic           fmt_single;
    logic           fmt_dual;
    logic           fmt_mem;
    logic           is_read;
    logic           cc_valid;
    logic [3:0]     cc_value;
    logic [24:0]    syn_bits;
    logic [5:0]     syn_class;

    // condition reporting shared by every format
    // wide-set traps always report a valid condition; the compact set
    // is a software-visible choice held in ctrl[0], so one build serves
    // both kinds of hypervisor without a respin
    always_comb
    begin
        // default: valid flag set, unconditional value
        cc_valid = 1'b1;
        cc_value = `TSE_CC_ALWAYS;
        if (trap_info_i.compact_set && !ctrl[0])
        begin
            // compact set, flag clear: value is don't-care, drive zero
            // so that the register read back stays deterministic
            cc_valid = 1'b0;
            cc_value = 4'h0;
        end
        else if (trap_info_i.conditional && !ctrl[1])
        begin
            // conditional instruction reports its own condition
            cc_value = trap_info_i.condition_code_field;
        end
        else
        begin
            // unconditional, or ctrl[1] folds passing conditions to 1110
            cc_value = `TSE_CC_ALWAYS;
        end
        // conditional traps are only taken after passing the check,
        // which is what makes the folded 1110 value legal
    end

    // format selection from the access kind and coprocessor
    always_comb
    begin
        fmt_single = 1'b0;
        fmt_dual   = 1'b0;
        fmt_mem    = 1'b0;
        is_read    = 1'b0;
        unique case (trap_info_i.kind)
            TSE_SINGLE_WRITE:
            begin
                fmt_single = 1'b1;
            end
            TSE_SINGLE_READ, TSE_FLOAT_READ:
            begin
                fmt_single = 1'b1;
                is_read    = 1'b1;
            end
            TSE_DUAL_WRITE:
            begin
                fmt_dual = (trap_info_i.coproc == `TSE_CP_SYS);
            end
            TSE_DUAL_READ:
            begin
                fmt_dual = (trap_info_i.coproc == `TSE_CP_SYS) ||
                           (trap_info_i.coproc == `TSE_CP_DBG);
                is_read  = 1'b1;
            end
            TSE_MEM_STORE:
            begin
                fmt_mem = 1'b1;
            end
            TSE_MEM_LOAD:
            begin
                fmt_mem = 1'b1;
                is_read = 1'b1;
            end
            default:
            begin
                fmt_single = 1'b0;
            end
        endcase
    end

    // syndrome assembly; unfilled bits stay zero as reserved
    // every field is written from a fixed position macro so that the
    // three formats can share one 25-bit vector without overlap checks
    // at run time; the overlap is by design (bits 8:5 and 4:1 recur)
    always_comb
    begin
        // reserved bits default to zero in every format
        syn_bits  = 25'h0;
        syn_class = `TSE_CLS_UNKNOWN;

        // condition and direction fields are common to all formats
        if (fmt_single || fmt_dual || fmt_mem)
        begin
            syn_bits[`TSE_POS_CC_VALID] = cc_valid;
            syn_bits[`TSE_POS_CC +: 4]  = cc_value;
            syn_bits[`TSE_POS_DIR]      = is_read;
        end

        if (fmt_single)
        begin
            // single-register transfer: register, opcode field, class
            // bits 19:10 belong to fields decoded elsewhere; zero here
            syn_bits[`TSE_POS_XFER +: 4] =
                trap_info_i.transfer_register_index;
            // float register read reports a fixed opcode field
            if (trap_info_i.kind == TSE_FLOAT_READ)
                syn_bits[`TSE_POS_SECOP +: 4] = `TSE_SECOP_FLOAT;
            else
                syn_bits[`TSE_POS_SECOP +: 4] =
                    trap_info_i.secondary_opcode_register_field;
            // identification reads override the coprocessor choice
            if (trap_info_i.id_group)
            begin
                syn_class = `TSE_CLS_ID_GROUP;
            end
            else if (trap_info_i.coproc == `TSE_CP_DBG)
            begin
                syn_class = `TSE_CLS_SINGLE_DBG;
            end
            else
            begin
                syn_class = `TSE_CLS_SINGLE_SYS;
            end
        end
        else if (fmt_dual)
        begin
            // dual-register transfer: both registers and opcode fields
            syn_bits[`TSE_POS_OPCODE_A +: 4] =
                trap_info_i.first_opcode_field;
            syn_bits[`TSE_POS_XFER2 +: 4] =
                trap_info_i.second_transfer_register_index;
            syn_bits[`TSE_POS_XFER +: 4] =
                trap_info_i.transfer_register_index;
            syn_bits[`TSE_POS_SECOP +: 4] =
                trap_info_i.secondary_opcode_register_field;
            // debug coprocessor gets its own class, everything else system
            if (trap_info_i.coproc == `TSE_CP_DBG)
            begin
                syn_class = `TSE_CLS_DUAL_DBG;
            end
            else
            begin
                syn_class = `TSE_CLS_DUAL_SYS;
            end
        end
        else if (fmt_mem)
        begin
            // memory load/store: immediate, base, offset sign, mode
            syn_bits[`TSE_POS_IMMEDIATE +: 8] =
                trap_info_i.eight_bit_immediate;
            // literal forms leave base unknown; zero is the cheap choice
            // and keeps the read-back free of stale register numbers
            if (!trap_info_i.addressing_mode_field[`TSE_MODE_LITERAL_BIT])
            begin
                syn_bits[`TSE_POS_XFER +: 4] =
                    trap_info_i.base_register_index;
            end
            syn_bits[`TSE_POS_OFFSET_DIR] = trap_info_i.offset_add;
            // reserved mode codes are passed through unchanged; the
            // decoder upstream is trusted not to trap on them
            syn_bits[`TSE_POS_ADDR_MODE +: 3] =
                trap_info_i.addressing_mode_field;
            syn_class = `TSE_CLS_MEM_COPROC;
        end
        else
        begin
            // unknown-reason class carries no syndrome at all
            syn_bits = 25'h0;
        end

        // pack the captured value
        next_syndrome.exception_class               = syn_class;
        next_syndrome.instruction_specific_syndrome = syn_bits;
    end

    // capture the syndrome on each trap strobe
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            syndrome_o <= '0;
            captured_o <= 1'b0;
        end
        else
        begin
            captured_o <= trap_i;
            if (trap_i)
                syndrome_o <= next_syndrome;
        end
    end

    // trap counter, wraps; gives software a visible event tally
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            trap_count <= 16'h0000;
        else if (trap_i)
            trap_count <= trap_count + 16'h0001;
    end

    // wishbone ack: one cycle after request, dropped the next cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= cyc_i && stb_i && !ack_o;
    end

    // control register write, lane 0 only
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl <= `TSE_CTRL_RESET;
        else if (cyc_i && stb_i && we_i && !ack_o && sel_i[0] &&
                 adr_i == `TSE_REG_CTRL)
            ctrl <= dat_i[1:0];
    end

    // read data registered with the ack; unmapped reads return zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h0000_0000;
        else if (cyc_i && stb_i && !we_i && !ack_o)
        begin
            unique case (adr_i)
                `TSE_REG_CTRL:     dat_o <= {30'h0, ctrl};
                `TSE_REG_SYNDROME: dat_o <= {7'h00, syndrome_o.instruction_specific_syndrome};
                `TSE_REG_CLASS:    dat_o <= {26'h0, syndrome_o.exception_class};
                `TSE_REG_COUNT:    dat_o <= {16'h0000, trap_count};
                default:           dat_o <= 32'h0000_0000;
            endcase
        end
    end

endmodule // tse_trap_syndrome_encoder

// >>> tse_trap_syndrome_encoder_asserts.sv
/*
 * Port-level checker for the trap syndrome encoder.
 * Assumes tse_pkg is compiled first; attached to the encoder by bind.
 */
`timescale 1ns/1ns

module tse_trap_syndrome_encoder_chk
    import tse_pkg::*;
(
    // clock and reset
    input wire logic          clk_i,
    input wire logic          rst_i,
    // trap capture
    input wire logic          trap_i,
    input wire tse_trap_t     trap_info_i,
    input wire logic          captured_o,
    input wire tse_syndrome_t syndrome_o,
    // wishbone handshake
    input wire logic          cyc_i,
    input wire logic          stb_i,
    input wire logic          ack_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // format selection from the trapped kind
    logic sgl;
    logic mem;
    assign sgl = trap_info_i.kind inside {TSE_SINGLE_WRITE, TSE_SINGLE_READ, TSE_FLOAT_READ};
    assign mem = trap_info_i.kind inside {TSE_MEM_STORE, TSE_MEM_LOAD};

    a_capture_delay: assert property (trap_i |=> captured_o) else $error("capture missing");
    a_hold_syndrome: assert property (!trap_i |=> $stable(syndrome_o) && !captured_o)
        else $error("syndrome moved without trap");
    a_single_xfer_reg: assert property (trap_i && sgl |=>
        syndrome_o.instruction_specific_syndrome[9:5]
        == {1'b0, $past(trap_info_i.transfer_register_index)}) else $error("single reg");
    a_dual_dbg_class: assert property (trap_i && trap_info_i.kind == TSE_DUAL_READ
        && trap_info_i.coproc == 4'hE |=> syndrome_o.exception_class == 6'h0C)
        else $error("dual debug class");
    a_mem_dir_bit: assert property (trap_i && mem |=> syndrome_o.instruction_specific_syndrome[0]
        == ($past(trap_info_i.kind) == TSE_MEM_LOAD)) else $error("mem direction");
    a_float_zero: assert property (trap_i && trap_info_i.kind == TSE_FLOAT_READ |=>
        syndrome_o.instruction_specific_syndrome[4:0] == 5'h01) else $error("float read");
    a_single_dir: assert property (trap_i && sgl |=> syndrome_o.instruction_specific_syndrome[0]
        == ($past(trap_info_i.kind) != TSE_SINGLE_WRITE)) else $error("single dir");
    a_id_class: assert property (trap_i && sgl && trap_info_i.id_group |=>
        syndrome_o.exception_class == 6'h08) else $error("id class");
    a_wide_valid: assert property (trap_i && !trap_info_i.compact_set && (sgl || mem) |=>
        syndrome_o.instruction_specific_syndrome[24]) else $error("wide valid");
    a_dual_opc: assert property (trap_i && trap_info_i.kind == TSE_DUAL_READ
        && trap_info_i.coproc == 4'hF |=> syndrome_o.exception_class == 6'h04
        && syndrome_o.instruction_specific_syndrome[19:16] == $past(trap_info_i.first_opcode_field))
        else $error("dual opc");
    a_mem_imm: assert property (trap_i && mem |=> syndrome_o.instruction_specific_syndrome[19:9]
        == {$past(trap_info_i.eight_bit_immediate), 3'h0}) else $error("mem imm");
    a_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
endmodule // tse_trap_syndrome_encoder_chk

bind tse_trap_syndrome_encoder tse_trap_syndrome_encoder_chk chk_u (.clk_i(clk_i),
    .rst_i(rst_i), .trap_i(trap_i), .trap_info_i(trap_info_i), .captured_o(captured_o),
    .syndrome_o(syndrome_o), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o));

// >>> tb_top.sv
/*
 * Self-checking bench for the trap syndrome encoder: random and corner traps.
 * Assumes the encoder, its package and its checker are compiled first.
 */
`timescale 1ns/1ns

module tb_top
    import tse_pkg::*;
;
    logic          clk_i = 0;
    logic          rst_i = 1;
    logic          trap_i = 0;
    tse_trap_t     trap_info_i = '0;
    logic          captured_o;
    tse_syndrome_t syndrome_o;
    logic          cyc_i = 0;
    logic          stb_i = 0;
    logic          we_i = 0;
    logic [7:0]    adr_i = 0;
    logic [3:0]    sel_i = 0;
    logic [31:0]   dat_i = 0;
    logic [31:0]   dat_o;
    logic          ack_o;
    logic [31:0]   rd;
    logic [1:0]    ctrl = 0;
    tse_trap_t     t;
    tse_syndrome_t last_e;
    int            bad_count = 0;
    int            samples_checked = 0;
    int            ntrap = 0;

    tse_trap_syndrome_encoder dut_u (.clk_i(clk_i), .rst_i(rst_i), .trap_i(trap_i),
        .trap_info_i(trap_info_i), .captured_o(captured_o), .syndrome_o(syndrome_o),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));

    // 20 MHz core clock
    always #25 clk_i = ~clk_i;

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] g, logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // classic cycle: hold until ack is seen, release at the following edge
    task automatic wb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        n = 0;
        do
        begin
            @(posedge clk_i);
            #1;
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            bad_count++;
            test_done();
        end
        r = dat_o;
        @(posedge clk_i);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask

    // expected syndrome; single-format bits 19:10 hold fields outside this block
    function automatic tse_syndrome_t exp_syn(tse_trap_t x, logic [1:0] c);
        logic [5:0]  cls;
        logic [24:0] i;
        logic        sgl;
        logic        mem;
        sgl = x.kind inside {TSE_SINGLE_WRITE, TSE_SINGLE_READ, TSE_FLOAT_READ};
        mem = x.kind inside {TSE_MEM_STORE, TSE_MEM_LOAD};
        cls = sgl ? (x.id_group ? 6'h08 : (x.coproc == 4'hE ? 6'h05 : 6'h03)) : mem ? 6'h06
            : x.coproc == 4'hF ? 6'h04
            : (x.coproc == 4'hE && x.kind == TSE_DUAL_READ) ? 6'h0C : 6'h00;
        i = '0;
        i[24] = !x.compact_set || c[0];
        if (i[24])
            i[23:20] = (x.conditional && !c[1]) ? x.condition_code_field : 4'hE;
        if (mem)
            i[19:0] = {x.eight_bit_immediate, 3'h0, x.addressing_mode_field[2] ? 4'h0
                : x.base_register_index, x.offset_add, x.addressing_mode_field, x.kind == TSE_MEM_LOAD};
        else
            i[19:0] = {sgl ? 4'h0 : x.first_opcode_field, 2'h0, sgl ? 4'h0
                : x.second_transfer_register_index, 1'b0, x.transfer_register_index,
                x.kind == TSE_FLOAT_READ ? 4'h0 : x.secondary_opcode_register_field,
                x.kind != TSE_SINGLE_WRITE && x.kind != TSE_DUAL_WRITE};
        return (cls == 6'h00) ? '0 : {cls, i};
    endfunction

    // one trap strobe, result checked one cycle later
    task automatic do_trap(tse_trap_t x);
        tse_syndrome_t m;
        m = (x.kind inside {TSE_SINGLE_WRITE, TSE_SINGLE_READ, TSE_FLOAT_READ})
            ? {11'h7FF, 10'h0, 10'h3FF} : '1;
        last_e = exp_syn(x, ctrl) & m;
        @(posedge clk_i);
        trap_i      <= 1'b1;
        trap_info_i <= x;
        @(posedge clk_i);
        trap_i <= 1'b0;
        #1;
        ntrap++;
        chk("captured", 32'(captured_o), 32'h1);
        chk("syndrome", 32'(syndrome_o & m), 32'(last_e));
    endtask

    // main sequence: reset, registers, corner and random traps per control setting
    initial
    begin
        void'($urandom(25461));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h00, 32'h0, rd);
        chk("ctrl reset", rd, 32'h0);
        wb(1'b1, 8'h10, 32'hFFFF_FFFF, rd);
        wb(1'b0, 8'h10, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        for (int c = 0; c < 4; c++)
        begin
            ctrl = 2'(c);
            wb(1'b1, 8'h00, 32'(c), rd);
            wb(1'b0, 8'h00, 32'h0, rd);
            chk("ctrl", rd, 32'(c));
            for (int k = 0; k < 17; k++)
            begin
                t = tse_trap_t'($bits(tse_trap_t)'({$urandom(), $urandom()}));
                t.kind = tse_kind_t'(k < 7 ? k : $urandom_range(6, 0));
                if ($urandom_range(3, 0) != 0)
                    t.coproc = {3'h7, 1'($urandom_range(1, 0))};
                t.addressing_mode_field[0] &= !t.addressing_mode_field[2];
                do_trap(t);
                do_trap(t);
            end
        end
        wb(1'b0, 8'h04, 32'h0, rd);
        chk("syndrome reg", rd & {7'h0, 25'(last_e) | 25'h1FFFFFF}, {7'h0, 25'(last_e)});
        wb(1'b0, 8'h08, 32'h0, rd);
        chk("class reg", rd, {26'h0, last_e.exception_class});
        wb(1'b0, 8'h0C, 32'h0, rd);
        chk("count", rd & 32'hFFFF, 32'(ntrap));
        test_done();
    end
endmodule // tb_top
